/* File: rtl/hiom_defs.svh */
// Function
// - Host hits only with a strobe low, address enable low, upper bits equal port A data.
// - Low host address bits pick output zero, register one, status or aux transmit.
// - With DMA mailbox one off, host write at 11 latches aux transmit register.
// - Output zero is processor read-only at D3, host read/write at 00.
// - At D4 processor reads output one and writes input one.
// - Enable bit is processor-written, reads zero at reset, blocks host when clear except unlock writes to 0FB and 0F9.
// - With enable clear, D3 to D5 are closed except writing the enable bit.
// - Status bits 6 to 4 are processor-written scratch bits, reset to zero.
// - Bit 3 sets on processor input-one write, clears on host read.
// - Bit 1 sets on host output-zero write, clears when a processor read empties the output zero buffer.
// - Host write to 0FB sets bit 0, write to 0F9 clears it.
// - Host reads or address-enable-high accesses leave bit 0 alone.
// - Status is processor read/write at D5, host read-only at 10.
`ifndef HIOM_DEFS_SVH
`define HIOM_DEFS_SVH

// ****************************************
// Processor register offsets
// ****************************************
`define HIOM_OFS_OUT0     8'hD3
`define HIOM_OFS_IO1      8'hD4
`define HIOM_OFS_STAT     8'hD5

// ****************************************
// Host function codes and fixed addresses
// ****************************************
`define HIOM_FN_OUT0      2'h0
`define HIOM_FN_IO1       2'h1
`define HIOM_FN_STAT      2'h2
`define HIOM_FN_AUX       2'h3
`define HIOM_UNLOCK_SET   10'h0FB
`define HIOM_UNLOCK_CLR   10'h0F9

// ****************************************
// Status field positions and reset values
// ****************************************
`define HIOM_ST_EN        7
`define HIOM_ST_SCR_HI    6
`define HIOM_ST_SCR_LO    4
`define HIOM_ST_IN1_AV    3
`define HIOM_ST_OUT0_AV   1
`define HIOM_ST_UNLOCK    0
`define HIOM_RST_BYTE     8'h00
`define HIOM_RST_SCR      3'h0

// ****************************************
// Output zero buffer
// ****************************************
`define HIOM_FIFO_WIDTH   8
`define HIOM_FIFO_DEPTH   32

`endif

/* File: rtl/hiom_pkg.sv */
`default_nettype none
package hiom_pkg;

  // Embedded processor I/O request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hiom_cpu_req_t;

  // Host I/O bus pins, strobes active low
  typedef struct packed {
    logic       rd_n;
    logic       wr_n;
    logic       addr_enable_n;
    logic [9:0] addr;
    logic [7:0] wdata;
  } hiom_host_bus_t;

endpackage : hiom_pkg
`default_nettype wire

/* File: rtl/hiom_mem.sv */
`default_nettype none
module hiom_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // Clock
  input  wire logic             clk_sys_i,
  // Write port
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  // Registered read port, write-first
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge clk_sys_i)
  begin
    if (we_i)
    begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  // Bypass keeps a push into an empty buffer visible next cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (we_i && (waddr_i == raddr_i))
    begin
      rdata_o <= wdata_i;
    end
    else
    begin
      rdata_o <= mem_r[raddr_i];
    end
  end

endmodule : hiom_mem
`default_nettype wire

/* File: rtl/hiom_fifo.sv */
`default_nettype none
module hiom_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             srst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic          push;
  logic          pop;
  logic [AW-1:0] raddr;
  logic [WIDTH-1:0] rdata;

  assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign raddr       = pop ? rd_ptr_r + AW'(1) : rd_ptr_r;
  // Empty buffer reads as zero, never stale or unknown words
  assign out_data_o  = out_valid_o ? rdata : '0;

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      if (push && !pop)
      begin
        count_r <= count_r + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
        count_r <= count_r - (AW+1)'(1);
      end
    end
  end

  hiom_mem #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clk_sys_i (clk_sys_i),
    .we_i      (push),
    .waddr_i   (wr_ptr_r),
    .wdata_i   (in_data_i),
    .raddr_i   (raddr),
    .rdata_o   (rdata)
  );

endmodule : hiom_fifo
`default_nettype wire

/* File: rtl/hiom_mailbox.sv */
`include "hiom_defs.svh"
`default_nettype none
module hiom_mailbox
  import hiom_pkg::*;
(
  // Clock and reset
  input  wire logic           clk_sys_i,
  input  wire logic           srst_i,
  // Embedded processor I/O bus
  input  wire hiom_cpu_req_t  cpu_req_i,
  output logic          [7:0] cpu_rdata_o,
  // Port A data and DMA mailbox one enable
  input  wire logic     [7:0] port_a_data_reg_i,
  input  wire logic           dma_mbox1_en_i,
  output logic          [7:0] dma_transmit_one_o,
  // Host I/O bus
  input  wire hiom_host_bus_t host_bus_i,
  output logic          [7:0] host_rdata_o,
  output logic                host_data_oe_o,
  output logic                host_ready_o
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic host_hit(input hiom_host_bus_t hb,
                                    input logic [7:0]     pad,
                                    input logic [1:0]     fn);
    host_hit = !hb.addr_enable_n && (hb.addr[9:2] == pad)
               && (hb.addr[1:0] == fn);
  endfunction : host_hit

  function automatic logic cpu_hit(input hiom_cpu_req_t rq,
                                   input logic [7:0]    ofs);
    cpu_hit = (rq.rd || rq.wr) && (rq.addr == ofs);
  endfunction : cpu_hit

  // ****************************************
  // State
  // ****************************************
  logic       enable_r;
  logic [2:0] scratch_r;
  logic       in1_avail_r;
  logic       unlock_r;
  logic [7:0] host_output_one_r;
  logic [7:0] host_input_one_r;
  logic [7:0] aux_tx_r;
  logic [7:0] cpu_rdata_r;
  logic [7:0] host_rdata_r;
  logic       host_rd_n_prev_r;
  logic       host_wr_n_prev_r;
  logic [7:0] status;
  logic       host_rd_ev;
  logic       host_wr_ev;
  logic       h_wr_out0;
  logic       h_wr_io1;
  logic       h_rd_io1;
  logic       h_wr_aux;
  logic       c_rd_out0;
  logic       c_wr_in1;
  logic       c_wr_stat;
  logic       out0_valid;
  logic [7:0] out0_head;

  // ****************************************
  // Host strobe edges
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      host_rd_n_prev_r <= 1'b1;
      host_wr_n_prev_r <= 1'b1;
    end
    else
    begin
      host_rd_n_prev_r <= host_bus_i.rd_n;
      host_wr_n_prev_r <= host_bus_i.wr_n;
    end
  end

  assign host_rd_ev = host_rd_n_prev_r && !host_bus_i.rd_n;
  assign host_wr_ev = host_wr_n_prev_r && !host_bus_i.wr_n;

  // Host side closed while the enable is clear
  assign h_wr_out0 = enable_r && host_wr_ev
    && host_hit(host_bus_i, port_a_data_reg_i, `HIOM_FN_OUT0);
  assign h_wr_io1  = enable_r && host_wr_ev
    && host_hit(host_bus_i, port_a_data_reg_i, `HIOM_FN_IO1);
  assign h_rd_io1  = enable_r && host_rd_ev
    && host_hit(host_bus_i, port_a_data_reg_i, `HIOM_FN_IO1);
  assign h_wr_aux  = enable_r && host_wr_ev && !dma_mbox1_en_i
    && host_hit(host_bus_i, port_a_data_reg_i, `HIOM_FN_AUX);

  // Processor side closed while the enable is clear, except status writes
  assign c_rd_out0 = enable_r && cpu_req_i.rd
    && cpu_hit(cpu_req_i, `HIOM_OFS_OUT0);
  assign c_wr_in1  = enable_r && cpu_req_i.wr
    && cpu_hit(cpu_req_i, `HIOM_OFS_IO1);
  assign c_wr_stat = cpu_req_i.wr && cpu_hit(cpu_req_i, `HIOM_OFS_STAT);

  // ****************************************
  // Output zero buffer, host fills, processor drains
  // ****************************************
  hiom_fifo #(
    .WIDTH (`HIOM_FIFO_WIDTH),
    .DEPTH (`HIOM_FIFO_DEPTH)
  ) u_out0_fifo (
    .clk_sys_i   (clk_sys_i),
    .srst_i      (srst_i),
    .in_valid_i  (h_wr_out0),
    .in_ready_o  (host_ready_o),
    .in_data_i   (host_bus_i.wdata),
    .out_valid_o (out0_valid),
    .out_ready_i (c_rd_out0),
    .out_data_o  (out0_head)
  );

  // ****************************************
  // Status register
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      enable_r  <= 1'b0;
      scratch_r <= `HIOM_RST_SCR;
    end
    else if (c_wr_stat)
    begin
      enable_r <= cpu_req_i.wdata[`HIOM_ST_EN];
      if (enable_r)
      begin
        scratch_r <= cpu_req_i.wdata[`HIOM_ST_SCR_HI:`HIOM_ST_SCR_LO];
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      in1_avail_r <= 1'b0;
    end
    else if (c_wr_in1)
    begin
      in1_avail_r <= 1'b1;
    end
    else if (h_rd_io1)
    begin
      in1_avail_r <= 1'b0;
    end
  end

  // Unlock flag ignores the enable and the data
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      unlock_r <= 1'b0;
    end
    else if (host_wr_ev && !host_bus_i.addr_enable_n)
    begin
      if (host_bus_i.addr == `HIOM_UNLOCK_SET)
      begin
        unlock_r <= 1'b1;
      end
      else if (host_bus_i.addr == `HIOM_UNLOCK_CLR)
      begin
        unlock_r <= 1'b0;
      end
    end
  end

  // Output-zero-available follows the buffer level
  assign status = {enable_r, scratch_r, in1_avail_r,
                   1'b0,
                   out0_valid,
                   unlock_r};

  // ****************************************
  // Data registers
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      host_output_one_r <= `HIOM_RST_BYTE;
    end
    else if (h_wr_io1)
    begin
      host_output_one_r <= host_bus_i.wdata;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      host_input_one_r <= `HIOM_RST_BYTE;
    end
    else if (c_wr_in1)
    begin
      host_input_one_r <= cpu_req_i.wdata;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      aux_tx_r <= `HIOM_RST_BYTE;
    end
    else if (h_wr_aux)
    begin
      aux_tx_r <= host_bus_i.wdata;
    end
  end

  assign dma_transmit_one_o = aux_tx_r;

  // ****************************************
  // Processor read data
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      cpu_rdata_r <= `HIOM_RST_BYTE;
    end
    else if (cpu_req_i.rd && enable_r)
    begin
      case (cpu_req_i.addr)
        `HIOM_OFS_OUT0: cpu_rdata_r <= out0_head;
        `HIOM_OFS_IO1:  cpu_rdata_r <= host_output_one_r;
        `HIOM_OFS_STAT: cpu_rdata_r <= status;
        default:        cpu_rdata_r <= `HIOM_RST_BYTE;
      endcase
    end
    else
    begin
      cpu_rdata_r <= `HIOM_RST_BYTE;
    end
  end

  assign cpu_rdata_o = cpu_rdata_r;

  // ****************************************
  // Host read data
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      host_rdata_r <= `HIOM_RST_BYTE;
    end
    else
    begin
      case (host_bus_i.addr[1:0])
        `HIOM_FN_OUT0: host_rdata_r <= out0_head;
        `HIOM_FN_IO1:  host_rdata_r <= host_input_one_r;
        `HIOM_FN_STAT: host_rdata_r <= status;
        default:       host_rdata_r <= `HIOM_RST_BYTE;
      endcase
    end
  end

  assign host_rdata_o   = host_rdata_r;
  // Aux address is write only, so the bus is left undriven there
  assign host_data_oe_o = enable_r && !host_bus_i.rd_n
    && !host_bus_i.addr_enable_n
    && (host_bus_i.addr[9:2] == port_a_data_reg_i)
    && (host_bus_i.addr[1:0] != `HIOM_FN_AUX);

  // ****************************************
  // Checks
  // ****************************************
  property p_host_closed;
    @(posedge clk_sys_i) disable iff (srst_i)
      !enable_r |-> !host_data_oe_o ##1 ($stable(out0_valid)
                    && $stable(host_output_one_r));
  endproperty
  a_host_closed: assert property (p_host_closed)
    else $error("host reached mailbox while disabled");

  property p_unlock_set;
    @(posedge clk_sys_i) disable iff (srst_i)
      (host_wr_ev && !host_bus_i.addr_enable_n
       && host_bus_i.addr == `HIOM_UNLOCK_SET)
        |=> status[`HIOM_ST_UNLOCK];
  endproperty
  a_unlock_set: assert property (p_unlock_set)
    else $error("unlock bit not set by host write");

  property p_unlock_hold;
    @(posedge clk_sys_i) disable iff (srst_i)
      !(host_wr_ev && !host_bus_i.addr_enable_n) |=> $stable(unlock_r);
  endproperty
  a_unlock_hold: assert property (p_unlock_hold)
    else $error("unlock bit moved without host write");

  property p_in1_set;
    @(posedge clk_sys_i) disable iff (srst_i)
      c_wr_in1 |=> status[`HIOM_ST_IN1_AV]
                   && host_input_one_r == $past(cpu_req_i.wdata);
  endproperty
  a_in1_set: assert property (p_in1_set)
    else $error("input one write not flagged");

  property p_in1_quiet;
    @(posedge clk_sys_i) disable iff (srst_i)
      (!enable_r && !in1_avail_r) |=> !in1_avail_r;
  endproperty
  a_in1_quiet: assert property (p_in1_quiet)
    else $error("input one flag set while disabled");

  property p_cpu_closed;
    @(posedge clk_sys_i) disable iff (srst_i)
      (cpu_req_i.rd && !enable_r) |=> cpu_rdata_o == `HIOM_RST_BYTE;
  endproperty
  a_cpu_closed: assert property (p_cpu_closed)
    else $error("processor read data while disabled");

  property p_aux_latch;
    @(posedge clk_sys_i) disable iff (srst_i)
      h_wr_aux |=> dma_transmit_one_o == $past(host_bus_i.wdata);
  endproperty
  a_aux_latch: assert property (p_aux_latch)
    else $error("aux transmit not latched");

  property p_scratch_hold;
    @(posedge clk_sys_i) disable iff (srst_i)
      !(c_wr_stat && enable_r) |=> $stable(scratch_r);
  endproperty
  a_scratch_hold: assert property (p_scratch_hold)
    else $error("scratch bits changed without processor write");

  property p_host_stat;
    @(posedge clk_sys_i) disable iff (srst_i)
      (host_bus_i.addr[1:0] == `HIOM_FN_STAT) |=>
        host_rdata_o == $past(status) && host_rdata_o[2] == 1'b0;
  endproperty
  a_host_stat: assert property (p_host_stat)
    else $error("host status read wrong");

endmodule : hiom_mailbox
`default_nettype wire

/* File: verification/hiom_host_model.sv */
`default_nettype none
module hiom_host_model
  import hiom_pkg::*;
(
  // Clock
  input  wire logic           clk_sys_i,
  // Host bus toward the mailbox
  output var hiom_host_bus_t  host_bus_o,
  input  wire logic     [7:0] host_rdata_i,
  input  wire logic           host_data_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    host_bus_o = '{1'b1, 1'b1, 1'b1, 10'h000, 8'h00};
  end

  // ****************************************
  // One strobed I/O cycle
  // ****************************************
  task automatic access(input logic wr, input logic aen_n,
                        input logic [9:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output logic oe);
    @(posedge clk_sys_i);
    host_bus_o.addr          <= a;
    host_bus_o.addr_enable_n <= aen_n;
    host_bus_o.wdata         <= d;
    @(posedge clk_sys_i);
    host_bus_o.rd_n <= wr;
    host_bus_o.wr_n <= !wr;
    repeat (2) @(posedge clk_sys_i);
    // Sample away from the edge that launches the read data
    @(negedge clk_sys_i);
    rd = host_rdata_i;
    oe = host_data_oe_i;
    @(posedge clk_sys_i);
    // Released data bus shows a changed value
    host_bus_o.rd_n  <= 1'b1;
    host_bus_o.wr_n  <= 1'b1;
    host_bus_o.wdata <= ~d;
    @(posedge clk_sys_i);
  endtask : access

endmodule : hiom_host_model
`default_nettype wire

/* File: verification/hiom_mailbox_tb.sv */
`include "hiom_defs.svh"
`default_nettype none
module hiom_mailbox_tb
  import hiom_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [9:0] BASE = 10'h100;

  logic           clk_sys_i;
  logic           srst_i;
  hiom_cpu_req_t  cpu_req;
  logic     [7:0] cpu_rdata;
  logic     [7:0] port_a;
  logic           dma_en;
  logic     [7:0] dma_tx;
  hiom_host_bus_t host_bus;
  logic     [7:0] host_rdata;
  logic           host_oe;
  logic           host_ready;
  logic     [7:0] h_rd;
  logic           h_oe;
  int             n_errors = 0;
  int             check_count = 0;

  hiom_mailbox u_hiom_mailbox (
    .clk_sys_i          (clk_sys_i),
    .srst_i             (srst_i),
    .cpu_req_i          (cpu_req),
    .cpu_rdata_o        (cpu_rdata),
    .port_a_data_reg_i  (port_a),
    .dma_mbox1_en_i     (dma_en),
    .dma_transmit_one_o (dma_tx),
    .host_bus_i         (host_bus),
    .host_rdata_o       (host_rdata),
    .host_data_oe_o     (host_oe),
    .host_ready_o       (host_ready)
  );

  hiom_host_model u_hiom_host_model (
    .clk_sys_i      (clk_sys_i),
    .host_bus_o     (host_bus),
    .host_rdata_i   (host_rdata),
    .host_data_oe_i (host_oe)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic cpu_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    cpu_req <= '{1'b0, 1'b1, a, d};
    @(posedge clk_sys_i);
    cpu_req <= '{1'b0, 1'b0, a, ~d};
  endtask : cpu_wr

  task automatic cpu_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    cpu_req <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clk_sys_i);
    cpu_req <= '{1'b0, 1'b0, a, 8'hFF};
    @(negedge clk_sys_i);
    check("cpu_rdata", cpu_rdata, exp);
  endtask : cpu_rd

  task automatic hacc(input logic wr, input logic aen_n,
                      input logic [9:0] a, input logic [7:0] d);
    u_hiom_host_model.access(wr, aen_n, a, d, h_rd, h_oe);
  endtask : hacc

  task automatic hrd(input logic [1:0] fn, input logic [7:0] exp,
                     input logic oe);
    hacc(1'b0, 1'b0, BASE | 10'(fn), 8'h00);
    check("host_data_oe", {7'h00, h_oe}, {7'h00, oe});
    if (oe)
      check("host_rdata", h_rd, exp);
  endtask : hrd

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    n_errors++;
    finish_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    srst_i  <= 1'b1;
    cpu_req <= '{1'b0, 1'b0, 8'h00, 8'h00};
    port_a  <= BASE[9:2];
    dma_en  <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(negedge clk_sys_i);
    check("host_ready", {7'h00, host_ready}, 8'h01);
    check("host_data_oe", {7'h00, host_oe}, 8'h00);
    hacc(1'b1, 1'b0, BASE, 8'h11);
    cpu_wr(`HIOM_OFS_IO1, 8'h22);
    hacc(1'b1, 1'b0, `HIOM_UNLOCK_SET, 8'hAA);
    cpu_rd(`HIOM_OFS_STAT, 8'h00);
    cpu_rd(`HIOM_OFS_OUT0, 8'h00);
    cpu_wr(`HIOM_OFS_STAT, 8'hF4);
    cpu_rd(`HIOM_OFS_STAT, 8'h81);
    cpu_wr(`HIOM_OFS_STAT, 8'hF4);
    cpu_rd(`HIOM_OFS_STAT, 8'hF1);
    hacc(1'b0, 1'b0, `HIOM_UNLOCK_CLR, 8'h00);
    hacc(1'b1, 1'b1, `HIOM_UNLOCK_CLR, 8'h00);
    cpu_rd(`HIOM_OFS_STAT, 8'hF1);
    hacc(1'b1, 1'b0, `HIOM_UNLOCK_CLR, 8'h55);
    hacc(1'b1, 1'b0, BASE | 10'h2, 8'h0F);
    hrd(2'h2, 8'hF0, 1'b1);
    hacc(1'b1, 1'b0, 10'h200, 8'h12);
    hacc(1'b1, 1'b1, BASE, 8'h13);
    cpu_rd(`HIOM_OFS_STAT, 8'hF0);
    hacc(1'b1, 1'b0, BASE, 8'h5A);
    hrd(2'h2, 8'hF2, 1'b1);
    hrd(2'h0, 8'h5A, 1'b1);
    cpu_rd(`HIOM_OFS_OUT0, 8'h5A);
    cpu_rd(`HIOM_OFS_STAT, 8'hF0);
    cpu_wr(`HIOM_OFS_IO1, 8'hA5);
    cpu_rd(`HIOM_OFS_STAT, 8'hF8);
    hrd(2'h1, 8'hA5, 1'b1);
    cpu_rd(`HIOM_OFS_STAT, 8'hF0);
    hacc(1'b1, 1'b0, BASE | 10'h1, 8'h3C);
    cpu_rd(`HIOM_OFS_IO1, 8'h3C);
    hacc(1'b1, 1'b0, BASE | 10'h3, 8'h77);
    check("dma_tx", dma_tx, 8'h77);
    dma_en <= 1'b1;
    hacc(1'b1, 1'b0, BASE | 10'h3, 8'h11);
    check("dma_tx", dma_tx, 8'h77);
    hrd(2'h3, 8'h00, 1'b0);
    dma_en <= 1'b0;
    cpu_rd(8'hD6, 8'h00);
    for (int i = 0; i < 32; i++)
      hacc(1'b1, 1'b0, BASE, 8'(i + 8'h30));
    check("host_ready", {7'h00, host_ready}, 8'h00);
    hacc(1'b1, 1'b0, BASE, 8'hEE);
    for (int i = 0; i < 32; i++)
      cpu_rd(`HIOM_OFS_OUT0, 8'(i + 8'h30));
    check("host_ready", {7'h00, host_ready}, 8'h01);
    cpu_rd(`HIOM_OFS_STAT, 8'hF0);
    cpu_wr(`HIOM_OFS_STAT, 8'h00);
    hacc(1'b1, 1'b0, BASE, 8'h99);
    cpu_wr(`HIOM_OFS_STAT, 8'h80);
    cpu_rd(`HIOM_OFS_STAT, 8'h80);
    // Mailbox left closed at the end
    cpu_wr(`HIOM_OFS_STAT, 8'h00);
    finish_test();
  end

endmodule : hiom_mailbox_tb
`default_nettype wire
